// [inc/gcrc_regs.svh]
// Register offsets, field positions, reset values and timing counts.
`ifndef GCRC_REGS_SVH
`define GCRC_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets
// ---------------------------------------------------------------
`define GCRC_CMD        8'h00
`define GCRC_CFG        8'h04
`define GCRC_STATUS     8'h08
`define GCRC_PRESET_CNT 8'h0C
`define GCRC_PRESET_TMR 8'h10
`define GCRC_MODE_LO    8'h14
`define GCRC_MODE_HI    8'h18
`define GCRC_MODE_ALL   8'h1C
`define GCRC_NET_ADDR   8'h20
`define GCRC_NET_PORT   8'h24
`define GCRC_DOWNLOAD   8'h28
`define GCRC_RX_CHAR    8'h2C
`define GCRC_ACQ_RADDR  8'h30
`define GCRC_ACQ_DATA   8'h34
`define GCRC_ACQ_COUNT  8'h38

// ---------------------------------------------------------------
// Command register bits
// ---------------------------------------------------------------
`define GCRC_CMD_START  0
`define GCRC_CMD_STOP   1
`define GCRC_CMD_ARM_C  2
`define GCRC_CMD_ARM_T  3
`define GCRC_CMD_CANCEL 4
`define GCRC_CMD_SRST   5
`define GCRC_CMD_SRC_LO 8
`define GCRC_CMD_SRC_HI 11

// ---------------------------------------------------------------
// Configuration bits
// ---------------------------------------------------------------
`define GCRC_CFG_ACQ    0
`define GCRC_CFG_EDGE   1
`define GCRC_CFG_SMALL  2
`define GCRC_CFG_INV_ST 3
`define GCRC_CFG_INV_SP 4
`define GCRC_CFG_INV_GT 5
`define GCRC_CFG_INV_RN 6
`define GCRC_CFG_RALL   7
`define GCRC_CFG_WIDEN  8
`define GCRC_CFG_W      9
`define GCRC_CFG_RESET  9'h000
`define GCRC_DL_RELEASE 8

// ---------------------------------------------------------------
// Reset values, sizes and timing
// ---------------------------------------------------------------
`define GCRC_NET_ADDR_RST 32'hC0A8_017B
`define GCRC_NET_PORT_RST 16'h1E61
`define GCRC_MODE_RST     32'h0000_0000
`define GCRC_DEPTH_LARGE  16'hDAC0
`define GCRC_DEPTH_SMALL  16'h1F40
`define GCRC_MAX_CONN     3'h7
`define GCRC_CHAR_CR      8'h0D
`define GCRC_CHAR_LF      8'h0A
`define GCRC_CLK_NS       50
`define GCRC_RUN_MIN_NS   10000
`define GCRC_RUN_MIN_CYC \
	((`GCRC_RUN_MIN_NS + `GCRC_CLK_NS - 1) / `GCRC_CLK_NS)

`endif

// [inc/gcrc_pkg.sv]
// Types shared by the run control block.
package gcrc_pkg;

	// Automatic stop selection.
	typedef enum logic [1:0]
	{
		GCRC_STOP_NONE  = 2'b00,
		GCRC_STOP_COUNT = 2'b01,
		GCRC_STOP_TIMER = 2'b10
	} gcrc_stop_mode_t;

	// Counting state.
	typedef enum logic
	{
		GCRC_IDLE = 1'b0,
		GCRC_RUN  = 1'b1
	} gcrc_state_t;

	// Per-pair input mode encoding.
	typedef enum logic [1:0]
	{
		GCRC_IN_TTL_HIZ = 2'b00,
		GCRC_IN_TTL_50  = 2'b01,
		GCRC_IN_NIM     = 2'b10
	} gcrc_in_mode_t;

endpackage

// [hw/gcrc_acq_mem.sv]
// Acquisition memory holding gate-synchronous count snapshots.
`timescale 1ns/1ps
`include "gcrc_regs.svh"

module gcrc_acq_mem (
	// Clock.
	input  wire logic        clk,
	// Write side.
	input  wire logic        we,
	input  wire logic [15:0] waddr,
	input  wire logic [31:0] wdata,
	// Read side.
	input  wire logic [15:0] raddr,
	output logic      [31:0] rdata
);

	logic [31:0] mem [0:`GCRC_DEPTH_LARGE-1];

	// Plain simple dual-port style array; read data is registered so that
	// the bus can sample it a full cycle after the address settles.
	always_ff @(posedge clk)
	begin
		if (we)
			mem[waddr] <= wdata;
		rdata <= mem[raddr];
	end

endmodule

// [hw/gcrc_run_ctrl.sv]
// Run control: start, stop, gate, run output, auto stop and host regs.
//
// Operation
// - A start edge begins counting on all channels until a stop.
// - A stop edge ends counting.
// - Host start and stop commands act exactly like the inputs.
// - Gate low suspends counting and the indicator; high resumes them.
// - In gate acquisition mode each gate fall stores the count data.
// - Memory holds 56000 entries, or 8000 on the small variant.
// - In gate edge acquisition mode counting continues while gate low.
// - Run output is high exactly while started and gate high.
// - Host may widen run pulses narrower than 10 us.
// - Command lines are ASCII ended by CR then LF.
// - In all-reply mode every command line gets an acknowledgement.
// - Arm count stop, save it; halt at preset; ignore in acquisition.
// - Arm timer stop, save it; halt at preset; ignore in acquisition.
// - Cancel auto stop, save it; only stop or acquisition end halts.
// - Input mode per pair or all pairs; reset value TTL high-Z.
// - Up to 8 connections, only one may own a download.
// - During download replies are suppressed; stop download still ok.
// - The most recent command source is the one acted upon.
// - Staged address and port apply only after a soft reset.
// - Start, stop, gate and run polarities are each invertible.
// - A start is refused while the armed auto stop limit is reached.
//
// Local design decisions: the APB interface to the registers and the address map.
`timescale 1ns/1ps
`include "gcrc_regs.svh"

module gcrc_run_ctrl (
	// Clock and reset.
	input  wire logic        clk,
	input  wire logic        rst_n,
	// APB slave.
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// External pins.
	input  wire logic        start_pin,
	input  wire logic        stop_pin,
	input  wire logic        gate_pin,
	output logic             run_pin,
	// Counter core.
	input  wire logic [31:0] preset_count_channel,
	input  wire logic [31:0] timer_value,
	input  wire logic [31:0] snap_data,
	output logic             count_en,
	output logic             led_on,
	output logic             snap_store,
	// Settings toward the front end and nonvolatile store.
	output logic [63:0]      in_mode,
	output logic             nv_save,
	output logic [1:0]       nv_stop_mode,
	output logic [31:0]      net_addr,
	output logic [15:0]      net_port,
	// Host link support.
	output logic             reply_en,
	output logic             reply_ack,
	output logic [3:0]       cmd_src
);

	// ---------------------------------------------------------------
	// Declarations
	// ---------------------------------------------------------------
	localparam int RUN_MIN = `GCRC_RUN_MIN_CYC;

	logic [2:0] start_s, stop_s, gate_s;
	logic       start_lv, stop_lv, gate_lv, gate_d;
	logic       start_d, stop_d, start_edge, stop_edge, gate_fall;
	logic       wr, rd_setup, hit;
	logic [31:0] next_prdata;

	logic [`GCRC_CFG_W-1:0] cfg, next_cfg;
	gcrc_pkg::gcrc_stop_mode_t stop_mode, next_stop_mode;
	logic [31:0] preset_cnt, next_preset_cnt;
	logic [31:0] preset_tmr, next_preset_tmr;
	logic [63:0] next_in_mode;
	logic [31:0] addr_stage, next_addr_stage, next_net_addr;
	logic [15:0] port_stage, next_port_stage, next_net_port;
	logic [3:0]  dl_owner, next_dl_owner, next_cmd_src;
	logic        cr_seen, next_cr_seen, next_reply_ack, next_nv_save;
	logic [15:0] acq_raddr, next_acq_raddr;

	gcrc_pkg::gcrc_state_t st, next_st;
	logic        start_ev, stop_ev, reached, acq_full, cmd_wr;
	logic [15:0] wr_ptr, next_wr_ptr, limit;
	logic [31:0] mem_rdata;
	logic        run_raw, run_raw_d, run_out;
	logic [7:0]  stretch, next_stretch;

	// Byte-offset decode used only by the error answer.
	function automatic logic is_mapped(input logic [7:0] a);
		is_mapped = (a[1:0] == 2'b00) && (a <= `GCRC_ACQ_COUNT);
	endfunction

	// ---------------------------------------------------------------
	// Pin synchronisers and edge detection
	// ---------------------------------------------------------------
	// Pins are asynchronous; only the second and third stages are looked at.
	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			start_s <= 3'h0;
			stop_s  <= 3'h0;
			gate_s  <= 3'h0;
			gate_d  <= 1'b1;
		end
		else
		begin
			start_s <= {start_s[1:0], start_pin};
			stop_s  <= {stop_s[1:0], stop_pin};
			gate_s  <= {gate_s[1:0], gate_pin};
			gate_d  <= gate_lv;
		end
	end

	// Polarity is applied after synchronising so each switch is a plain
	// exclusive-or; the third stage holds the previous level for edges.
	assign start_lv   = start_s[1] ^ cfg[`GCRC_CFG_INV_ST];
	assign stop_lv    = stop_s[1] ^ cfg[`GCRC_CFG_INV_SP];
	assign gate_lv    = gate_s[1] ^ cfg[`GCRC_CFG_INV_GT];
	assign start_d    = start_s[2] ^ cfg[`GCRC_CFG_INV_ST];
	assign stop_d     = stop_s[2] ^ cfg[`GCRC_CFG_INV_SP];
	assign start_edge = start_lv & ~start_d;
	assign stop_edge  = stop_lv & ~stop_d;
	assign gate_fall  = gate_d & ~gate_lv;

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	// Zero wait states: read data is captured in the setup cycle.
	assign wr       = psel & penable & pwrite;
	assign rd_setup = psel & ~penable & ~pwrite;
	assign hit      = is_mapped(paddr);
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hit;
	assign cmd_wr   = wr & (paddr == `GCRC_CMD);

	// Read mux; the status word packs the live run state.
	always_comb
	begin
		next_prdata = prdata;
		if (rd_setup)
		begin
			case (paddr)
				`GCRC_CFG:        next_prdata = {23'h0, cfg};
				`GCRC_STATUS:     next_prdata = {18'h0, cmd_src, dl_owner,
					acq_full, reached, stop_mode, run_out, st};
				`GCRC_PRESET_CNT: next_prdata = preset_cnt;
				`GCRC_PRESET_TMR: next_prdata = preset_tmr;
				`GCRC_MODE_LO:    next_prdata = in_mode[31:0];
				`GCRC_MODE_HI:    next_prdata = in_mode[63:32];
				`GCRC_NET_ADDR:   next_prdata = addr_stage;
				`GCRC_NET_PORT:   next_prdata = {16'h0, port_stage};
				`GCRC_DOWNLOAD:   next_prdata = {28'h0, dl_owner};
				`GCRC_ACQ_RADDR:  next_prdata = {16'h0, acq_raddr};
				`GCRC_ACQ_DATA:   next_prdata = mem_rdata;
				`GCRC_ACQ_COUNT:  next_prdata = {16'h0, wr_ptr};
				default:          next_prdata = 32'h0000_0000;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	always_comb
	begin
		next_cfg        = cfg;
		next_stop_mode  = stop_mode;
		next_preset_cnt = preset_cnt;
		next_preset_tmr = preset_tmr;
		next_in_mode    = in_mode;
		next_addr_stage = addr_stage;
		next_port_stage = port_stage;
		next_net_addr   = net_addr;
		next_net_port   = net_port;
		next_acq_raddr  = acq_raddr;
		next_nv_save    = 1'b0;
		if (wr)
		begin
			case (paddr)
				`GCRC_CFG:        next_cfg = pwdata[`GCRC_CFG_W-1:0];
				`GCRC_PRESET_CNT: next_preset_cnt = pwdata;
				`GCRC_PRESET_TMR: next_preset_tmr = pwdata;
				`GCRC_MODE_LO:    next_in_mode[31:0] = pwdata;
				`GCRC_MODE_HI:    next_in_mode[63:32] = pwdata;
				`GCRC_MODE_ALL:   next_in_mode = {32{pwdata[1:0]}};
				`GCRC_NET_ADDR:   next_addr_stage = pwdata;
				`GCRC_NET_PORT:   next_port_stage = pwdata[15:0];
				`GCRC_ACQ_RADDR:  next_acq_raddr = pwdata[15:0];
				default:          next_cfg = cfg;
			endcase
		end
		// Arming is refused in acquisition mode so a snapshot run is
		// never cut short by a stale preset.
		if (cmd_wr && !cfg[`GCRC_CFG_ACQ])
		begin
			if (pwdata[`GCRC_CMD_ARM_C])
			begin
				next_stop_mode = gcrc_pkg::GCRC_STOP_COUNT;
				next_nv_save   = 1'b1;
			end
			else if (pwdata[`GCRC_CMD_ARM_T])
			begin
				next_stop_mode = gcrc_pkg::GCRC_STOP_TIMER;
				next_nv_save   = 1'b1;
			end
		end
		if (cmd_wr && pwdata[`GCRC_CMD_CANCEL])
		begin
			next_stop_mode = gcrc_pkg::GCRC_STOP_NONE;
			next_nv_save   = 1'b1;
		end
		// Staged network settings go live only here.
		if (cmd_wr && pwdata[`GCRC_CMD_SRST])
		begin
			next_net_addr = addr_stage;
			next_net_port = port_stage;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cfg        <= `GCRC_CFG_RESET;
			stop_mode  <= gcrc_pkg::GCRC_STOP_NONE;
			preset_cnt <= 32'h0000_0000;
			preset_tmr <= 32'h0000_0000;
			in_mode    <= {2{`GCRC_MODE_RST}};
			addr_stage <= `GCRC_NET_ADDR_RST;
			port_stage <= `GCRC_NET_PORT_RST;
			net_addr   <= `GCRC_NET_ADDR_RST;
			net_port   <= `GCRC_NET_PORT_RST;
			acq_raddr  <= 16'h0000;
			nv_save    <= 1'b0;
			prdata     <= 32'h0000_0000;
		end
		else
		begin
			cfg        <= next_cfg;
			stop_mode  <= next_stop_mode;
			preset_cnt <= next_preset_cnt;
			preset_tmr <= next_preset_tmr;
			in_mode    <= next_in_mode;
			addr_stage <= next_addr_stage;
			port_stage <= next_port_stage;
			net_addr   <= next_net_addr;
			net_port   <= next_net_port;
			acq_raddr  <= next_acq_raddr;
			nv_save    <= next_nv_save;
			prdata     <= next_prdata;
		end
	end

	assign nv_stop_mode = stop_mode;

	// ---------------------------------------------------------------
	// Host link: framing, download ownership, command source
	// ---------------------------------------------------------------
	// Software feeds each received character; a CR then LF ends a line.
	always_comb
	begin
		next_cr_seen   = cr_seen;
		next_reply_ack = 1'b0;
		next_dl_owner  = dl_owner;
		next_cmd_src   = cmd_src;
		if (wr && paddr == `GCRC_RX_CHAR)
		begin
			next_cr_seen = (pwdata[7:0] == `GCRC_CHAR_CR);
			next_reply_ack = cr_seen &&
				(pwdata[7:0] == `GCRC_CHAR_LF) &&
				cfg[`GCRC_CFG_RALL] && !dl_owner[3];
		end
		// One owner at a time; a release is always taken so a stuck
		// download can be ended from any connection.
		if (wr && paddr == `GCRC_DOWNLOAD)
		begin
			if (pwdata[`GCRC_DL_RELEASE])
				next_dl_owner = 4'h0;
			else if (!dl_owner[3])
				next_dl_owner = {1'b1, pwdata[2:0]};
		end
		if (cmd_wr)
			next_cmd_src = pwdata[`GCRC_CMD_SRC_HI:`GCRC_CMD_SRC_LO];
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			cr_seen   <= 1'b0;
			reply_ack <= 1'b0;
			dl_owner  <= 4'h0;
			cmd_src   <= 4'h0;
		end
		else
		begin
			cr_seen   <= next_cr_seen;
			reply_ack <= next_reply_ack;
			dl_owner  <= next_dl_owner;
			cmd_src   <= next_cmd_src;
		end
	end

	assign reply_en = ~dl_owner[3];

	// ---------------------------------------------------------------
	// Run state and acquisition
	// ---------------------------------------------------------------
	assign reached = (stop_mode == gcrc_pkg::GCRC_STOP_COUNT &&
		preset_count_channel >= preset_cnt) ||
		(stop_mode == gcrc_pkg::GCRC_STOP_TIMER &&
		timer_value >= preset_tmr);
	assign limit    = cfg[`GCRC_CFG_SMALL] ? `GCRC_DEPTH_SMALL
		: `GCRC_DEPTH_LARGE;
	// Full only counts while running, so a filled memory cannot block
	// the next start that clears the pointer.
	assign acq_full = cfg[`GCRC_CFG_ACQ] && (st == gcrc_pkg::GCRC_RUN) &&
		(wr_ptr == limit);
	assign start_ev = start_edge | (cmd_wr & pwdata[`GCRC_CMD_START]);
	assign stop_ev  = stop_edge | (cmd_wr & pwdata[`GCRC_CMD_STOP]) |
		acq_full;
	assign snap_store = (st == gcrc_pkg::GCRC_RUN) && gate_fall &&
		cfg[`GCRC_CFG_ACQ] && !acq_full;

	// Stop wins over a simultaneous start; a reached limit blocks start.
	always_comb
	begin
		next_st     = st;
		next_wr_ptr = wr_ptr;
		case (st)
			gcrc_pkg::GCRC_IDLE:
				if (start_ev && !stop_ev && !reached)
				begin
					next_st     = gcrc_pkg::GCRC_RUN;
					next_wr_ptr = 16'h0000;
				end
			gcrc_pkg::GCRC_RUN:
				if (stop_ev || reached)
					next_st = gcrc_pkg::GCRC_IDLE;
			default:
				next_st = gcrc_pkg::GCRC_IDLE;
		endcase
		if (snap_store)
			next_wr_ptr = wr_ptr + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			st     <= gcrc_pkg::GCRC_IDLE;
			wr_ptr <= 16'h0000;
		end
		else
		begin
			st     <= next_st;
			wr_ptr <= next_wr_ptr;
		end
	end

	gcrc_acq_mem u_mem (
		.clk   (clk),
		.we    (snap_store),
		.waddr (wr_ptr),
		.wdata (snap_data),
		.raddr (acq_raddr),
		.rdata (mem_rdata)
	);

	// ---------------------------------------------------------------
	// Count enable and run output with optional widening
	// ---------------------------------------------------------------
	assign run_raw  = (st == gcrc_pkg::GCRC_RUN) && gate_lv;
	assign led_on   = run_raw;
	assign count_en = (st == gcrc_pkg::GCRC_RUN) &&
		(gate_lv || cfg[`GCRC_CFG_EDGE]);

	// With widening on, each rising run loads the minimum width; the output stays up
	// until both the level and the stretch count are gone.
	always_comb
	begin
		next_stretch = (stretch != 8'h00) ? stretch - 8'h01 : 8'h00;
		if (run_raw && !run_raw_d && cfg[`GCRC_CFG_WIDEN])
			next_stretch = 8'(RUN_MIN - 1);
	end

	always_ff @(posedge clk)
	begin
		if (!rst_n)
		begin
			stretch   <= 8'h00;
			run_raw_d <= 1'b0;
		end
		else
		begin
			stretch   <= next_stretch;
			run_raw_d <= run_raw;
		end
	end

	assign run_out = run_raw | (stretch != 8'h00);
	assign run_pin = run_out ^ cfg[`GCRC_CFG_INV_RN];

	// ---------------------------------------------------------------
	// Assertions
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_n);

	a_run_level: assert property (!cfg[`GCRC_CFG_WIDEN] &&
		stretch == 8'h00 |-> (run_pin ^ cfg[`GCRC_CFG_INV_RN]) ==
		((st == gcrc_pkg::GCRC_RUN) && gate_lv))
		else $error("run level wrong");
	a_gate_suspend: assert property (
		!gate_lv && !cfg[`GCRC_CFG_EDGE] |-> !count_en && !led_on)
		else $error("gate low did not suspend");
	a_edge_keeps: assert property (
		st == gcrc_pkg::GCRC_RUN && cfg[`GCRC_CFG_EDGE] |-> count_en)
		else $error("edge mode stopped counting");
	a_start_enters: assert property (st == gcrc_pkg::GCRC_IDLE &&
		start_ev && !stop_ev && !reached |=> st == gcrc_pkg::GCRC_RUN)
		else $error("start not taken");
	a_stop_leaves: assert property (
		st == gcrc_pkg::GCRC_RUN && stop_ev |=> st == gcrc_pkg::GCRC_IDLE)
		else $error("stop not taken");
	a_refuse_start: assert property (
		st == gcrc_pkg::GCRC_IDLE && reached |=> st == gcrc_pkg::GCRC_IDLE)
		else $error("start taken at limit");
	a_widen_load: assert property (run_raw && !run_raw_d &&
		cfg[`GCRC_CFG_WIDEN] |=> stretch == 8'(RUN_MIN - 1))
		else $error("widen count wrong");
	a_acq_store: assert property (snap_store |=>
		wr_ptr == $past(wr_ptr) + 16'h0001)
		else $error("snapshot pointer stuck");
	a_arm_ignored: assert property (cmd_wr &&
		cfg[`GCRC_CFG_ACQ] && !pwdata[`GCRC_CMD_CANCEL] |=>
		$stable(stop_mode)) else $error("arm taken in acquisition");
	a_net_hold: assert property (
		!(cmd_wr && pwdata[`GCRC_CMD_SRST]) |=> $stable(net_addr))
		else $error("address changed without reset");

endmodule

// [sim/gcrc_pin_src.sv]
// Model of the external source that drives start, stop and gate.
`timescale 1ns/1ps

module gcrc_pin_src (
	// Clock.
	input  wire logic clk,
	// Pins toward the block.
	output logic      start_pin,
	output logic      stop_pin,
	output logic      gate_pin
);
	// ---------------------------------------------------------------
	// Pin drivers
	// ---------------------------------------------------------------
	// Gate idles high as if pulled up; start and stop idle low.
	initial
	begin
		start_pin = 1'h0;
		stop_pin  = 1'h0;
		gate_pin  = 1'h1;
	end

	// Three clocks (150 ns) is over the minimum width.
	// Start is always low again before a stop is sent.
	task automatic pulse(input logic is_stop);
		@(posedge clk);
		start_pin <= ~is_stop;
		stop_pin  <= is_stop;
		repeat (3) @(posedge clk);
		start_pin <= 1'h0;
		stop_pin  <= 1'h0;
	endtask

	// Gate changes level just after an edge and then stands.
	task automatic set_gate(input logic lvl);
		@(posedge clk);
		gate_pin <= lvl;
	endtask
endmodule

// [sim/testbench.sv]
// Self-checking bench for the run control block.
`timescale 1ns/1ps
`include "gcrc_regs.svh"

module testbench;
	// ---------------------------------------------------------------
	// Signals and instances
	// ---------------------------------------------------------------
	logic        clk, rst_n, psel, penable, pwrite, pready, pslverr;
	logic        start_pin, stop_pin, gate_pin, run_pin, count_en;
	logic        led_on, snap_store, nv_save, reply_en, reply_ack, err;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, pcc, tmr, last_snap, net_addr, rd;
	logic [63:0] in_mode;
	logic [1:0]  nv_stop_mode;
	logic [15:0] net_port;
	logic [3:0]  cmd_src;
	int          num_errors = 0;
	int          compares = 0;
	int          n_nv = 0;
	int          n_snap = 0;
	int          n_ack = 0;

	gcrc_pin_src src_u (.clk(clk), .start_pin(start_pin),
		.stop_pin(stop_pin), .gate_pin(gate_pin));

	gcrc_run_ctrl dut_u (.clk(clk), .rst_n(rst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .start_pin(start_pin), .stop_pin(stop_pin),
		.gate_pin(gate_pin), .run_pin(run_pin),
		.preset_count_channel(pcc), .timer_value(tmr), .snap_data(pcc),
		.count_en(count_en), .led_on(led_on), .snap_store(snap_store),
		.in_mode(in_mode), .nv_save(nv_save),
		.nv_stop_mode(nv_stop_mode), .net_addr(net_addr),
		.net_port(net_port), .reply_en(reply_en),
		.reply_ack(reply_ack), .cmd_src(cmd_src));

	// Free-running 20 MHz clock.
	initial
	begin
		clk = 1'h0;
		forever #25 clk = ~clk;
	end

	// Pulses are counted so a doubled or missing pulse is seen.
	always @(posedge clk)
	begin
		if (nv_save === 1'h1) n_nv <= n_nv + 1;
		if (snap_store === 1'h1)
		begin
			n_snap    <= n_snap + 1;
			last_snap <= pcc;
		end
		if (reply_ack === 1'h1) n_ack <= n_ack + 1;
	end

	// Counter core model: the preset channel and the timer advance
	// only while the block enables counting.
	always @(posedge clk)
	begin
		if (rst_n !== 1'h1)
		begin
			pcc <= 32'h0000_0000;
			tmr <= 32'h0000_0000;
		end
		else if (count_en === 1'h1)
		begin
			pcc <= pcc + 32'h0000_0001;
			tmr <= tmr + 32'h0000_0002;
		end
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	// Compare one value and count it.
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		compares++;
		if (got !== exp)
		begin
			num_errors++;
			$display("wrong value at %0t: got %h expected %h", $time,
				got, exp);
		end
	endtask

	// Let n edges pass, then step off the edge.
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask

	// One APB transfer; read data and error are taken at the ready edge.
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int n;
		@(posedge clk);
		psel    <= 1'h1;
		penable <= 1'h0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'h1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'h1 && n < 16);
		rd  = prdata;
		err = pslverr;
		psel    <= 1'h0;
		penable <= 1'h0;
		if (pready !== 1'h1)
		begin
			num_errors++;
			test_done;
		end
		#1;
	endtask

	// Print the counts and the verdict, then stop.
	task automatic test_done;
		$display("compares %0d mismatches %0d", compares, num_errors);
		if (num_errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	// Reset values and a refused unmapped access.
	task automatic t_reset;
		apb(1'h0, `GCRC_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0000);
		chk({net_addr, net_port}, {32'hC0A8_017B, 16'h1E61});
		chk(in_mode, 64'h0000_0000_0000_0000);
		chk({reply_en, run_pin, count_en}, 3'h4);
		apb(1'h0, 8'h3C, 32'h0000_0000);
		chk({err, rd}, {1'h1, 32'h0000_0000});
		$display("reset test done");
	endtask

	// Start, gate and stop from the pins.
	task automatic t_pins;
		src_u.pulse(1'h0);
		cyc(3);
		chk({count_en, led_on, run_pin}, 3'h7);
		src_u.set_gate(1'h0);
		cyc(4);
		chk({count_en, led_on, run_pin}, 3'h0);
		src_u.set_gate(1'h1);
		cyc(4);
		chk({count_en, led_on, run_pin}, 3'h7);
		src_u.pulse(1'h1);
		cyc(3);
		chk({count_en, run_pin}, 2'h0);
		$display("pin test done");
	endtask

	// Host start and stop, and the recorded command source.
	task automatic t_cmd;
		apb(1'h1, `GCRC_CMD, 32'h0000_0001);
		cyc(3);
		chk(count_en, 1'h1);
		apb(1'h1, `GCRC_CMD, 32'h0000_0302);
		cyc(3);
		chk({count_en, cmd_src}, 5'h03);
		apb(1'h0, `GCRC_STATUS, 32'h0000_0000);
		chk(rd, 32'h0000_0C00);
		$display("command test done");
	endtask

	// Arm count stop, timer stop, then cancel; each is saved once.
	task automatic t_auto;
		int b;
		logic [31:0] p;
		b = n_nv;
		p = pcc + 32'h0000_0005;
		apb(1'h1, `GCRC_PRESET_CNT, p);
		apb(1'h1, `GCRC_CMD, 32'h0000_0004);
		cyc(2);
		chk({n_nv - b, nv_stop_mode}, {32'h0000_0001, 2'h1});
		apb(1'h1, `GCRC_CMD, 32'h0000_0001);
		cyc(3);
		chk(count_en, 1'h1);
		cyc(8);
		chk({count_en, pcc >= p}, 2'h1);
		apb(1'h1, `GCRC_CMD, 32'h0000_0001);
		cyc(3);
		chk(count_en, 1'h0);
		p = tmr + 32'h0000_0020;
		apb(1'h1, `GCRC_PRESET_TMR, p);
		apb(1'h1, `GCRC_CMD, 32'h0000_0008);
		apb(1'h1, `GCRC_CMD, 32'h0000_0001);
		cyc(3);
		chk({n_nv - b, nv_stop_mode, count_en}, {32'h2, 3'h5});
		cyc(20);
		chk({count_en, tmr >= p}, 2'h1);
		apb(1'h1, `GCRC_CMD, 32'h0000_0010);
		apb(1'h1, `GCRC_CMD, 32'h0000_0001);
		cyc(3);
		chk({n_nv - b, nv_stop_mode, count_en}, {32'h3, 3'h1});
		apb(1'h1, `GCRC_CMD, 32'h0000_0002);
		$display("auto stop test done");
	endtask

	// Gate acquisition stores on gate fall; edge mode keeps counting.
	task automatic t_acq;
		int b;
		apb(1'h1, `GCRC_CFG, 32'h0000_0001);
		apb(1'h1, `GCRC_CMD, 32'h0000_0004);
		cyc(2);
		chk(nv_stop_mode, 2'h0);
		b = n_snap;
		apb(1'h1, `GCRC_CMD, 32'h0000_0001);
		src_u.set_gate(1'h0);
		cyc(5);
		chk(n_snap - b, 32'h0000_0001);
		src_u.set_gate(1'h1);
		apb(1'h0, `GCRC_ACQ_COUNT, 32'h0000_0000);
		chk(rd, 32'h0000_0001);
		apb(1'h0, `GCRC_ACQ_DATA, 32'h0000_0000);
		chk(rd, last_snap);
		apb(1'h1, `GCRC_CFG, 32'h0000_0003);
		src_u.set_gate(1'h0);
		cyc(5);
		chk(count_en, 1'h1);
		src_u.set_gate(1'h1);
		apb(1'h1, `GCRC_CMD, 32'h0000_0002);
		apb(1'h1, `GCRC_CFG, 32'h0000_0000);
		$display("acquisition test done");
	endtask

	// Staged network settings, input modes and a widened run pulse.
	task automatic t_set;
		apb(1'h1, `GCRC_NET_ADDR, 32'hC0A8_013C);
		apb(1'h1, `GCRC_NET_PORT, 32'h0000_2AF7);
		chk(net_addr, 32'hC0A8_017B);
		apb(1'h1, `GCRC_CMD, 32'h0000_0020);
		cyc(2);
		chk({net_addr, net_port}, {32'hC0A8_013C, 16'h2AF7});
		apb(1'h1, `GCRC_MODE_ALL, 32'h0000_0002);
		apb(1'h1, `GCRC_MODE_LO, 32'h0000_0001);
		cyc(1);
		chk(in_mode, 64'hAAAA_AAAA_0000_0001);
		apb(1'h1, `GCRC_CFG, 32'h0000_0100);
		apb(1'h1, `GCRC_CMD, 32'h0000_0001);
		apb(1'h1, `GCRC_CMD, 32'h0000_0002);
		cyc(100);
		chk(run_pin, 1'h1);
		cyc(150);
		chk(run_pin, 1'h0);
		apb(1'h1, `GCRC_CFG, 32'h0000_0040);
		chk(run_pin, 1'h1);
		$display("settings test done");
	endtask

	// Line ends, reply-all, and replies held back during a download.
	task automatic t_link;
		int b;
		b = n_ack;
		apb(1'h1, `GCRC_CFG, 32'h0000_0080);
		apb(1'h1, `GCRC_RX_CHAR, 32'h0000_000D);
		apb(1'h1, `GCRC_RX_CHAR, 32'h0000_000A);
		apb(1'h1, `GCRC_RX_CHAR, 32'h0000_000A);
		cyc(2);
		chk(n_ack - b, 32'h0000_0001);
		apb(1'h1, `GCRC_DOWNLOAD, 32'h0000_0001);
		apb(1'h1, `GCRC_DOWNLOAD, 32'h0000_0002);
		apb(1'h0, `GCRC_DOWNLOAD, 32'h0000_0000);
		chk({rd, reply_en}, {32'h0000_0009, 1'h0});
		apb(1'h1, `GCRC_RX_CHAR, 32'h0000_000D);
		apb(1'h1, `GCRC_RX_CHAR, 32'h0000_000A);
		apb(1'h1, `GCRC_DOWNLOAD, 32'h0000_0100);
		cyc(2);
		chk({n_ack - b, reply_en}, {32'h0000_0001, 1'h1});
		$display("link test done");
	endtask

	// ---------------------------------------------------------------
	// Main sequence and hang guard
	// ---------------------------------------------------------------
	// Drive every input at time zero, reset for ten clocks, run all.
	initial
	begin
		rst_n   = 1'h0;
		psel    = 1'h0;
		penable = 1'h0;
		pwrite  = 1'h0;
		paddr   = 8'h00;
		pwdata  = 32'h0000_0000;
		repeat (10) @(posedge clk);
		rst_n <= 1'h1;
		cyc(3);
		t_reset;
		t_pins;
		t_cmd;
		t_auto;
		t_acq;
		t_set;
		t_link;
		test_done;
	end

	// A run that outlasts this bound is cut short as a failure.
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		test_done;
	end
endmodule
